// ### hw/actc_pkg.sv
// Package: register map, field layout and carrier types for the channel trim bank
package actc_pkg;

    localparam int          ACTC_AW             = 8;
    localparam int          ACTC_DW             = 8;

    localparam logic [7:0]  ACTC_ADDR_GAIN_TRIM  = 8'h3f;
    localparam logic [7:0]  ACTC_ADDR_PHASE_TRIM = 8'h40;
    localparam logic [7:0]  ACTC_ADDR_INPUT_SETUP = 8'h41;

    localparam logic [7:0]  ACTC_RST_GAIN_TRIM   = 8'h80;
    localparam logic [7:0]  ACTC_RST_PHASE_TRIM  = 8'h00;
    localparam logic [7:0]  ACTC_RST_INPUT_SETUP = 8'h10;

    localparam logic [3:0]  ACTC_GAIN_UNITY      = 4'h8;
    localparam int          ACTC_GAIN_LSB        = 4;
    localparam logic [7:0]  ACTC_GAIN_RSVD_MASK  = 8'h0f;

    localparam int          ACTC_BIT_KIND        = 7;
    localparam int          ACTC_BIT_COUPLING    = 4;
    localparam int          ACTC_BIT_SWING       = 3;
    localparam int          ACTC_BIT_AUTO_GAIN   = 0;
    localparam int          ACTC_CFG_LSB         = 5;
    localparam int          ACTC_AMP_LSB         = 1;

    localparam logic [1:0]  ACTC_AMP_HIGH_SNR    = 2'h0;
    localparam logic [1:0]  ACTC_AMP_HIGH_CMRR   = 2'h2;

    // Decoded channel 2 input setup
    typedef struct packed {
        logic       ch2_input_kind;        // 0 mic, 1 line
        logic [1:0] ch2_input_config;      // 0 diff, 1 single-ended
        logic       ch2_coupling_sel;      // 0 AC, 1 DC
        logic       ch2_swing_range;       // 0 low, 1 high
        logic [1:0] ch2_amp_rejection_sel; // 0 high SNR, 2 high CMRR
        logic       ch2_auto_gain_on;
    } actc_input_setup_s;

    // Host port access
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ACTC_AW-1:0]  addr;
        logic [ACTC_DW-1:0]  wdata;
    } actc_host_req_s;

endpackage

// ### hw/actc_phase_delay.sv
// Programmable delay line for channel 1 in modulator clock cycles
`timescale 1ns/100ps
`default_nettype none
module actc_phase_delay
    import actc_pkg::*;
#(
    parameter int DEPTH = 255,
    parameter int DW    = 1
)(
    input  wire logic          clk,      // System clock
    input  wire logic          sys_rst,  // Async reset, active high
    input  wire logic          mod_tick, // Modulator clock strobe
    input  wire logic [7:0]    delay,    // Delay in modulator cycles
    input  wire logic [DW-1:0] din,      // Modulator stream in
    output logic      [DW-1:0] dout      // Delayed stream out
);

    logic [DW-1:0] tap_ff [DEPTH];

    // Shift chain; tap_ff[k] holds the sample k+1 ticks old
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                tap_ff[i] <= '0;
        end
        else if (mod_tick)
        begin
            tap_ff[0] <= din;
            for (int i = 1; i < DEPTH; i++)
                tap_ff[i] <= tap_ff[i-1];
        end
    end

    // Zero bypasses the chain entirely
    always_comb
    begin
        if (delay == 8'h00)
            dout = din;
        else
            dout = tap_ff[delay - 8'h01];
    end

endmodule
`default_nettype wire

// ### hw/actc_trim_regs.sv
// Channel 1 trim and channel 2 input setup register bank
`timescale 1ns/100ps
`default_nettype none
module actc_trim_regs
    import actc_pkg::*;
#(
    parameter int DELAY_DEPTH = 255,
    parameter int SAMPLE_W    = 1
)(
    input  wire logic                 clk,              // 20 MHz system clock
    input  wire logic                 sys_rst,          // Async reset, active high
    input  wire actc_host_req_s       host_req,         // Control port access
    output logic [ACTC_DW-1:0]        rdata,            // Read data, registered
    output logic                      rvalid,           // Read data valid pulse
    input  wire logic                 mod_tick,         // Modulator clock strobe
    input  wire logic [SAMPLE_W-1:0]  ch1_mod_in,       // Channel 1 modulator stream
    output logic      [SAMPLE_W-1:0]  ch1_mod_out,      // Phase-trimmed stream
    output logic [3:0]                ch1_gain_trim,    // Gain trim code to decimator
    output logic signed [4:0]         ch1_gain_tenth_db, // Gain offset in 0.1 dB
    output logic [7:0]                ch1_phase_delay,  // Phase delay in cycles
    output var actc_input_setup_s     ch2_setup         // Channel 2 front-end setup
);

    logic [3:0]         ch1_gain_trim_field_ff;
    logic [7:0]         ch1_phase_delay_field_ff;
    logic [ACTC_DW-1:0] ch2_input_setup_reg_ff;
    logic [ACTC_DW-1:0] nxt_rdata;
    logic               wr_gain;
    logic               wr_phase;
    logic               wr_setup;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    assign wr_gain  = host_req.wr && hit(host_req.addr, ACTC_ADDR_GAIN_TRIM);
    assign wr_phase = host_req.wr && hit(host_req.addr, ACTC_ADDR_PHASE_TRIM);
    assign wr_setup = host_req.wr && hit(host_req.addr, ACTC_ADDR_INPUT_SETUP);

    // Only the upper nibble is stored; reserved bits cannot hold a value
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ch1_gain_trim_field_ff <= ACTC_RST_GAIN_TRIM[7:ACTC_GAIN_LSB];
        else if (wr_gain)
            ch1_gain_trim_field_ff <= host_req.wdata[7:ACTC_GAIN_LSB];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ch1_phase_delay_field_ff <= ACTC_RST_PHASE_TRIM;
        else if (wr_phase)
            ch1_phase_delay_field_ff <= host_req.wdata;
    end

    // All codes stored as written; reserved codes are the host's to avoid
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ch2_input_setup_reg_ff <= ACTC_RST_INPUT_SETUP;
        else if (wr_setup)
            ch2_input_setup_reg_ff <= host_req.wdata;
    end

    always_comb
    begin
        nxt_rdata = '0;
        if (hit(host_req.addr, ACTC_ADDR_GAIN_TRIM))
            nxt_rdata = {ch1_gain_trim_field_ff, 4'h0};
        else if (hit(host_req.addr, ACTC_ADDR_PHASE_TRIM))
            nxt_rdata = ch1_phase_delay_field_ff;
        else if (hit(host_req.addr, ACTC_ADDR_INPUT_SETUP))
            nxt_rdata = ch2_input_setup_reg_ff;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata <= '0;
        else if (host_req.rd)
            rdata <= nxt_rdata;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rvalid <= 1'b0;
        else
            rvalid <= host_req.rd;
    end

    assign ch1_gain_trim     = ch1_gain_trim_field_ff;
    // Signed offset: code minus unity code gives tenths of a dB
    assign ch1_gain_tenth_db = $signed({1'b0, ch1_gain_trim_field_ff})
                             - $signed({1'b0, ACTC_GAIN_UNITY});
    assign ch1_phase_delay   = ch1_phase_delay_field_ff;

    always_comb
    begin
        ch2_setup.ch2_input_kind        = ch2_input_setup_reg_ff[ACTC_BIT_KIND];
        ch2_setup.ch2_input_config      = ch2_input_setup_reg_ff[ACTC_CFG_LSB +: 2];
        ch2_setup.ch2_coupling_sel      = ch2_input_setup_reg_ff[ACTC_BIT_COUPLING];
        ch2_setup.ch2_swing_range       = ch2_input_setup_reg_ff[ACTC_BIT_SWING];
        ch2_setup.ch2_amp_rejection_sel = ch2_input_setup_reg_ff[ACTC_AMP_LSB +: 2];
        ch2_setup.ch2_auto_gain_on      = ch2_input_setup_reg_ff[ACTC_BIT_AUTO_GAIN];
    end

    actc_phase_delay #(
        .DEPTH (DELAY_DEPTH),
        .DW    (SAMPLE_W)
    ) actc_phase_delay_inst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .mod_tick (mod_tick),
        .delay    (ch1_phase_delay_field_ff),
        .din      (ch1_mod_in),
        .dout     (ch1_mod_out)
    );

    property p_gain_write;
        @(posedge clk) disable iff (sys_rst)
        wr_gain |=> ch1_gain_trim == $past(host_req.wdata[7:4]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain trim not stored");

    property p_gain_unity;
        @(posedge clk) disable iff (sys_rst)
        (ch1_gain_trim == 4'h8) |-> (ch1_gain_tenth_db == 5'sd0);
    endproperty
    a_gain_unity: assert property (p_gain_unity) else $error("unity code not 0 dB");

    property p_gain_range;
        @(posedge clk) disable iff (sys_rst)
        (ch1_gain_trim == 4'h0) |-> (ch1_gain_tenth_db == -5'sd8);
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain code 0 not -0.8 dB");

    property p_gain_rsvd;
        @(posedge clk) disable iff (sys_rst)
        (host_req.rd && host_req.addr == 8'h3f) |=> rvalid && rdata[3:0] == 4'h0;
    endproperty
    a_gain_rsvd: assert property (p_gain_rsvd) else $error("reserved bits not zero");

    property p_phase_zero;
        @(posedge clk) disable iff (sys_rst)
        (ch1_phase_delay == 8'h00) |-> ch1_mod_out == ch1_mod_in;
    endproperty
    a_phase_zero: assert property (p_phase_zero) else $error("zero delay not bypassed");

    property p_phase_one;
        @(posedge clk) disable iff (sys_rst)
        (ch1_phase_delay == 8'h01 && mod_tick) ##1 (ch1_phase_delay == 8'h01)
            |-> ch1_mod_out == $past(ch1_mod_in);
    endproperty
    a_phase_one: assert property (p_phase_one) else $error("one cycle delay wrong");

    property p_setup_readback;
        @(posedge clk) disable iff (sys_rst)
        wr_setup ##1 (host_req.rd && host_req.addr == 8'h41 && !host_req.wr)
            |=> rdata == $past(host_req.wdata, 2);
    endproperty
    a_setup_readback: assert property (p_setup_readback) else $error("setup readback wrong");

    property p_setup_hold;
        @(posedge clk) disable iff (sys_rst)
        !wr_setup |=> $stable(ch2_setup);
    endproperty
    a_setup_hold: assert property (p_setup_hold) else $error("setup changed without write");

    property p_coupling_map;
        @(posedge clk) disable iff (sys_rst)
        wr_setup |=> ch2_setup.ch2_coupling_sel == $past(host_req.wdata[4])
                  && ch2_setup.ch2_input_kind == $past(host_req.wdata[7]);
    endproperty
    a_coupling_map: assert property (p_coupling_map) else $error("field mapping wrong");

    property p_phase_write;
        @(posedge clk) disable iff (sys_rst)
        wr_phase |=> ch1_phase_delay == $past(host_req.wdata);
    endproperty
    a_phase_write: assert property (p_phase_write) else $error("phase trim not stored");

    property p_config_map;
        @(posedge clk) disable iff (sys_rst)
        wr_setup |=> ch2_setup.ch2_input_config == $past(host_req.wdata[6:5]);
    endproperty
    a_config_map: assert property (p_config_map) else $error("input config mapping wrong");

    property p_swing_map;
        @(posedge clk) disable iff (sys_rst)
        wr_setup |=> ch2_setup.ch2_swing_range == $past(host_req.wdata[3]);
    endproperty
    a_swing_map: assert property (p_swing_map) else $error("swing range mapping wrong");

    property p_amp_map;
        @(posedge clk) disable iff (sys_rst)
        wr_setup |=> ch2_setup.ch2_amp_rejection_sel == $past(host_req.wdata[2:1]);
    endproperty
    a_amp_map: assert property (p_amp_map) else $error("amplifier setting mapping wrong");

    property p_auto_gain_map;
        @(posedge clk) disable iff (sys_rst)
        wr_setup |=> ch2_setup.ch2_auto_gain_on == $past(host_req.wdata[0]);
    endproperty
    a_auto_gain_map: assert property (p_auto_gain_map) else $error("auto gain mapping wrong");

endmodule
`default_nettype wire

// ### tb/actc_host_model.sv
// Host-side model that drives register writes and reads on the control port
`timescale 1ns/100ps
`default_nettype none
module actc_host_model
    import actc_pkg::*;
(
    input  wire logic               clk,      // System clock
    output var actc_host_req_s      host_req, // Control port access
    input  wire logic [ACTC_DW-1:0] rdata,    // Read data
    input  wire logic               rvalid    // Read data valid
);
    initial host_req = '0;

    // Software habits: reserved bits and illegal codes never leave the host
    function automatic logic [7:0] legal_data(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == ACTC_ADDR_GAIN_TRIM)
            d = d & ~ACTC_GAIN_RSVD_MASK;
        if (addr == ACTC_ADDR_INPUT_SETUP)
        begin
            d = d & 8'hbd;
            if (d[ACTC_BIT_COUPLING])
                d[ACTC_BIT_AUTO_GAIN] = 1'b0;
        end
        return d;
    endfunction

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: legal_data(addr, data)};
        @(posedge clk);
        host_req.wr <= 1'b0;
    endtask

    // Back-to-back write then read of one address, no idle cycle between
    task automatic write_read(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd_data,
                              output logic ok);
        ok = 1'b0;
        rd_data = 8'h00;
        @(posedge clk);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: legal_data(addr, data)};
        @(posedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        host_req.rd <= 1'b0;
        #1;
        if (rvalid === 1'b1)
        begin
            rd_data = rdata;
            ok = 1'b1;
        end
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        host_req.rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (rvalid === 1'b1)
            begin
                data = rdata;
                ok = 1'b1;
            end
            else
                @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### tb/test_adc_channel_trim_config_regs.sv
// Self-checking bench for the channel trim and input setup register bank
`timescale 1ns/100ps
`default_nettype none
module test_adc_channel_trim_config_regs
    import actc_pkg::*;
;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              mod_tick = 1'b0;
    logic [0:0]        ch1_mod_in = 1'b0;
    logic [0:0]        ch1_mod_out;
    actc_host_req_s    host_req;
    logic [7:0]        rdata;
    logic [7:0]        ch1_phase_delay;
    logic              rvalid;
    logic [3:0]        ch1_gain_trim;
    logic signed [4:0] ch1_gain_tenth_db;
    actc_input_setup_s ch2_setup;
    int                n_errors = 0;
    int                compares = 0;
    logic [11:0]       pat = 12'hb2e;
    logic [7:0]        setup_tbl [7] = '{8'h90, 8'h30, 8'h00, 8'h18, 8'h04, 8'h05, 8'h10};
    int                dly_tbl [3] = '{3, 255, 1};

    initial
    begin
        forever #25 clk = ~clk;
    end

    actc_trim_regs #(.SAMPLE_W(1)) actc_trim_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .host_req(host_req), .rdata(rdata), .rvalid(rvalid),
        .mod_tick(mod_tick), .ch1_mod_in(ch1_mod_in), .ch1_mod_out(ch1_mod_out),
        .ch1_gain_trim(ch1_gain_trim), .ch1_gain_tenth_db(ch1_gain_tenth_db),
        .ch1_phase_delay(ch1_phase_delay), .ch2_setup(ch2_setup));

    actc_host_model actc_host_model_inst (
        .clk(clk), .host_req(host_req), .rdata(rdata), .rvalid(rvalid));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        actc_host_model_inst.read_reg(addr, d, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            print_verdict();
        end
        else
            check(d, exp);
    endtask

    task automatic wr_rd_chk(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        logic       ok;
        actc_host_model_inst.write_read(addr, data, d, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            print_verdict();
        end
        else
            check(d, data);
    endtask

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic chk_defaults();
        rd_chk(ACTC_ADDR_GAIN_TRIM, 8'h80);
        rd_chk(ACTC_ADDR_PHASE_TRIM, 8'h00);
        rd_chk(ACTC_ADDR_INPUT_SETUP, 8'h10);
        check({4'h0, ch1_gain_trim}, 8'h08);
        check(ch1_phase_delay, 8'h00);
        check(ch2_setup, 8'h10);
    endtask

    initial
    begin
        do_reset();
        chk_defaults();
        for (int k = 0; k < 16; k++)
        begin
            actc_host_model_inst.write_reg(ACTC_ADDR_GAIN_TRIM, {k[3:0], 4'h0});
            rd_chk(ACTC_ADDR_GAIN_TRIM, {k[3:0], 4'h0});
            check({3'h0, ch1_gain_tenth_db}, {3'h0, 5'(k - 8)});
        end
        actc_host_model_inst.write_reg(ACTC_ADDR_PHASE_TRIM, 8'hff);
        rd_chk(ACTC_ADDR_PHASE_TRIM, 8'hff);
        check(ch1_phase_delay, 8'hff);
        foreach (setup_tbl[i])
        begin
            wr_rd_chk(ACTC_ADDR_INPUT_SETUP, setup_tbl[i]);
            check(ch2_setup, setup_tbl[i]);
        end
        // Unmapped neighbour must neither store nor disturb its neighbours
        actc_host_model_inst.write_reg(8'h42, 8'h5a);
        rd_chk(8'h42, 8'h00);
        rd_chk(ACTC_ADDR_INPUT_SETUP, 8'h10);
        rd_chk(ACTC_ADDR_GAIN_TRIM, 8'hf0);
        // Short 3-cycle delay, full 255-cycle end point, then single cycle
        foreach (dly_tbl[p])
        begin
            actc_host_model_inst.write_reg(ACTC_ADDR_PHASE_TRIM, 8'(dly_tbl[p]));
            for (int k = 0; k < dly_tbl[p] + 9; k++)
            begin
                @(posedge clk);
                mod_tick <= 1'b1;
                ch1_mod_in <= pat[k % 12];
                @(negedge clk);
                if (k >= dly_tbl[p])
                    check({7'h0, ch1_mod_out}, {7'h0, pat[(k - dly_tbl[p]) % 12]});
            end
        end
        actc_host_model_inst.write_reg(ACTC_ADDR_PHASE_TRIM, 8'h00);
        @(posedge clk);
        mod_tick <= 1'b0;
        ch1_mod_in <= 1'b1;
        @(negedge clk);
        check({7'h0, ch1_mod_out}, 8'h01);
        do_reset();
        chk_defaults();
        print_verdict();
    end
endmodule
`default_nettype wire
